/* File: core/memory_map_bank_decoder.sv */
// Contract
// R1: separate program and data buses, same cycle
// R2: 13-bit program counter, 8K word space
// R3: small variant implements words 0000h-03FFh
// R4: large variant implements words 0000h-07FFh
// R5: fetches above implemented range wrap around
// R6: reset vector 0000h, interrupt vector 0004h
// R7: status bits 6:5 select bank 0-3
// R8: each bank spans 128 byte offsets
// R9: low offsets special registers, rest RAM
// R10: every bank holds special function registers
// R11: status register mirrored in all banks
// R12: direct or indirect addressing via pointer
// R13: EEPROM only via pointer, not mapped
// R14: direct address is bank bits plus offset
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.svh"
module memory_map_bank_decoder #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       sys_rst_in,
    // program side
    input  wire logic                       pc_advance_in,
    input  wire logic                       pc_jump_in,
    input  wire logic [`PC_WIDTH-1:0]       pc_target_in,
    input  wire logic                       irq_accept_in,
    input  wire logic                       rom_load_en_in,
    input  wire logic [`PC_WIDTH-1:0]       rom_load_addr_in,
    input  wire logic [13:0]                rom_load_word_in,
    output logic      [`PC_WIDTH-1:0]       pc_out,
    output logic      [13:0]                fetch_word_out,
    // data side
    input  wire logic                       data_rd_in,
    input  wire logic                       data_wr_in,
    input  wire logic [`REG_ADDR_WIDTH-1:0] reg_addr_in,
    input  wire logic [7:0]                 wr_data_in,
    output logic      [7:0]                 data_rd_out,
    output logic      [`DATA_ADDR_WIDTH-1:0] data_addr_out,
    output logic      [1:0]                 region_out,
    output logic                            periph_sel_out,
    output logic      [7:0]                 status_out,
    output logic      [7:0]                 indirect_pointer_reg_out,
    // eeprom pointer port
    input  wire logic                       ee_ptr_wr_in,
    input  wire logic [7:0]                 ee_ptr_in,
    output logic      [7:0]                 ee_addr_out
);
    localparam int PROG_BITS = LARGE_VARIANT ? `LARGE_PROG_BITS : `SMALL_PROG_BITS; // see R3 see R4
    localparam int EE_BITS   = LARGE_VARIANT ? `LARGE_EE_BITS : `SMALL_EE_BITS;
    localparam int GPR_WORDS = LARGE_VARIANT ? `LARGE_GPR_WORDS : `SMALL_GPR_WORDS;

    logic [`PC_WIDTH-1:0]        pc_q;
    logic [7:0]                  status_q;
    logic [7:0]                  pointer_q;
    logic [`DATA_ADDR_WIDTH-1:0] addr_d;
    logic [`REG_ADDR_WIDTH-1:0]  ofs_d;
    mem_map_pkg::region_type     region_d;
    logic [7:0]                  gpr_mem [0:GPR_WORDS-1];
    logic [7:0]                  rd_d;

    // ======================================================
    // program counter
    // interrupt outranks jump and step in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pc_q <= `RESET_VECTOR; // see R6
        end else if (irq_accept_in) begin
            pc_q <= `IRQ_VECTOR; // see R6
        end else if (pc_jump_in) begin
            pc_q <= pc_target_in;
        end else if (pc_advance_in) begin
            pc_q <= pc_q + `PC_STEP; // see R2
        end
    end
    assign pc_out = pc_q;

    // own bus: fetch runs in parallel with any data access
    prog_rom_port #(
        .ADDR_BITS(PROG_BITS)
    ) u_rom (
        .ref_clk_in    (ref_clk_in),
        .fetch_addr_in (pc_q),
        .load_en_in    (rom_load_en_in),
        .load_addr_in  (rom_load_addr_in),
        .load_word_in  (rom_load_word_in),
        .fetch_word_out(fetch_word_out)
    ); // see R1 see R5

    // ======================================================
    // address formation
    function automatic mem_map_pkg::region_type classify(input logic [`REG_ADDR_WIDTH-1:0] ofs);
        if (ofs == `INDIRECT_OFS) begin
            classify = mem_map_pkg::region_indirect;
        end else if (ofs == `STATUS_OFS || ofs == `POINTER_OFS || ofs == `PCL_OFS) begin
            classify = mem_map_pkg::region_core; // see R11
        end else if (ofs < `SPECIAL_LIMIT) begin
            classify = mem_map_pkg::region_special; // see R9 see R10
        end else begin
            classify = mem_map_pkg::region_gpr; // see R9
        end
    endfunction

    // true when an access lands on one mirrored core register
    function automatic logic core_hit(input mem_map_pkg::region_type region,
                                      input logic [`REG_ADDR_WIDTH-1:0] ofs,
                                      input logic [`REG_ADDR_WIDTH-1:0] target);
        core_hit = (region == mem_map_pkg::region_core) && (ofs == target);
    endfunction

    always_comb begin
        // offset 00h redirects through the pointer; status bit 6 picks bank pair
        if (reg_addr_in == `INDIRECT_OFS) begin
            addr_d = {status_q[`BANK_HI_BIT], pointer_q}; // see R12
        end else begin
            addr_d = {status_q[`BANK_HI_BIT], status_q[`BANK_LO_BIT], reg_addr_in}; // see R7 see R14
        end
        ofs_d    = addr_d[`REG_ADDR_WIDTH-1:0]; // see R8
        region_d = classify(ofs_d);
        // indirect through offset 00h itself reads as zero
        if (reg_addr_in == `INDIRECT_OFS && region_d == mem_map_pkg::region_indirect) begin
            region_d = mem_map_pkg::region_special;
        end
    end

    // ======================================================
    // core registers, mirrored in every bank
    // bank select bits live here, so a write rebanks the very next access
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            status_q <= `STATUS_RESET;
        end else if (data_wr_in && core_hit(region_d, ofs_d, `STATUS_OFS)) begin
            status_q <= wr_data_in; // see R11
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pointer_q <= `POINTER_RESET;
        end else if (data_wr_in && core_hit(region_d, ofs_d, `POINTER_OFS)) begin
            pointer_q <= wr_data_in; // see R12
        end
    end

    // ======================================================
    // general purpose ram; small part folds banks 1-3 onto bank 0 space
    // no reset on ram: contents stay undefined until software writes them
    function automatic int gpr_index(input logic [`DATA_ADDR_WIDTH-1:0] a);
        gpr_index = LARGE_VARIANT ? int'({a[7], a[6:0]}) : int'(a[6:0]);
    endfunction

    always_ff @(posedge ref_clk_in) begin
        if (data_wr_in && region_d == mem_map_pkg::region_gpr) begin
            gpr_mem[gpr_index(addr_d)] <= wr_data_in; // see R9
        end
    end

    always_comb begin
        rd_d = 8'h00;
        if (region_d == mem_map_pkg::region_gpr) begin
            rd_d = gpr_mem[gpr_index(addr_d)];
        end else if (region_d == mem_map_pkg::region_core) begin
            if (ofs_d == `STATUS_OFS) begin
                rd_d = status_q;
            end else if (ofs_d == `POINTER_OFS) begin
                rd_d = pointer_q;
            end else begin
                rd_d = pc_q[7:0];
            end
        end
    end

    // ======================================================
    // registered outputs, one register per concern
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            data_rd_out <= `DATA_IDLE;
        end else begin
            data_rd_out <= data_rd_in ? rd_d : `DATA_IDLE;
        end
    end

    // address and region follow every cycle so the far side can decode early
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            data_addr_out <= '0;
        end else begin
            data_addr_out <= addr_d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            region_out <= 2'(mem_map_pkg::region_special);
        end else begin
            region_out <= 2'(region_d);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            periph_sel_out <= 1'b0;
        end else begin
            periph_sel_out <= (data_rd_in || data_wr_in) && region_d == mem_map_pkg::region_special;
        end
    end
    assign status_out               = status_q;
    assign indirect_pointer_reg_out = pointer_q;

    // ======================================================
    // eeprom pointer: separate from data map
    // small part keeps bit 7 low so the pointer never leaves its 128 bytes
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ee_addr_out <= `EE_RESET;
        end else if (ee_ptr_wr_in) begin
            ee_addr_out <= {(EE_BITS == 8) ? ee_ptr_in[7] : 1'b0, ee_ptr_in[6:0]}; // see R13
        end
    end
endmodule
`default_nettype wire

/* File: core/mem_map_consts.svh */
`ifndef MEM_MAP_CONSTS_SVH
`define MEM_MAP_CONSTS_SVH
`define PC_WIDTH        13
`define RESET_VECTOR    13'h0000
`define IRQ_VECTOR      13'h0004
`define STATUS_RESET    8'h18
`define BANK_HI_BIT     6
`define BANK_LO_BIT     5
`define REG_ADDR_WIDTH  7
`define DATA_ADDR_WIDTH 9
`define INDIRECT_OFS    7'h00
`define PCL_OFS         7'h02
`define STATUS_OFS      7'h03
`define POINTER_OFS     7'h04
`define SPECIAL_LIMIT   7'h20
`define SHARED_BASE     7'h70
`define SMALL_PROG_BITS 10
`define LARGE_PROG_BITS 11
`define SMALL_EE_BITS   7
`define LARGE_EE_BITS   8
`define SMALL_GPR_WORDS 128
`define LARGE_GPR_WORDS 256
`define PC_STEP         13'h0001
`define POINTER_RESET   8'h00
`define DATA_IDLE       8'h00
`define EE_RESET        8'h00
`endif

/* File: core/mem_map_pkg.sv */
package mem_map_pkg;
    typedef enum logic [1:0] {
        region_special,
        region_gpr,
        region_indirect,
        region_core
    } region_type;
endpackage

/* File: core/prog_rom_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.svh"
module prog_rom_port #(
    parameter int ADDR_BITS = `SMALL_PROG_BITS
) (
    input  wire logic                  ref_clk_in,
    input  wire logic [`PC_WIDTH-1:0]  fetch_addr_in,
    input  wire logic                  load_en_in,
    input  wire logic [`PC_WIDTH-1:0]  load_addr_in,
    input  wire logic [13:0]           load_word_in,
    output logic      [13:0]           fetch_word_out
);
    logic [13:0] rom_mem [0:(1<<ADDR_BITS)-1];

    // upper pc bits dropped: every alias hits the same word
    always_ff @(posedge ref_clk_in) begin
        fetch_word_out <= rom_mem[fetch_addr_in[ADDR_BITS-1:0]]; // see R5
    end

    always_ff @(posedge ref_clk_in) begin
        if (load_en_in) begin
            rom_mem[load_addr_in[ADDR_BITS-1:0]] <= load_word_in;
        end
    end
endmodule
`default_nettype wire

/* File: tb/memory_map_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.svh"
module memory_map_checker #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic                        ref_clk_in,
    input wire logic                        sys_rst_in,
    input wire logic                        pc_advance_in,
    input wire logic                        pc_jump_in,
    input wire logic [`PC_WIDTH-1:0]        pc_target_in,
    input wire logic                        irq_accept_in,
    input wire logic [`PC_WIDTH-1:0]        pc_out,
    input wire logic                        data_rd_in,
    input wire logic                        data_wr_in,
    input wire logic [`REG_ADDR_WIDTH-1:0]  reg_addr_in,
    input wire logic [7:0]                  data_rd_out,
    input wire logic [`DATA_ADDR_WIDTH-1:0] data_addr_out,
    input wire logic [1:0]                  region_out,
    input wire logic                        periph_sel_out,
    input wire logic [7:0]                  status_out,
    input wire logic [7:0]                  indirect_pointer_reg_out,
    input wire logic                        ee_ptr_wr_in,
    input wire logic [7:0]                  ee_ptr_in,
    input wire logic [7:0]                  ee_addr_out
);
    logic acc;
    assign acc = data_rd_in | data_wr_in;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ====================
    // program side
    reset_vector_a: assert property ($fell(sys_rst_in) |-> pc_out == `RESET_VECTOR)
        else $error("pc not at reset vector");
    irq_vector_a: assert property (irq_accept_in |=> pc_out == `IRQ_VECTOR)
        else $error("pc not at interrupt vector");
    pc_jump_a: assert property (pc_jump_in && !irq_accept_in |=> pc_out == $past(pc_target_in))
        else $error("jump target not loaded");
    // 13-bit sum wraps to zero at the top of the space
    pc_step_a: assert property (pc_advance_in && !pc_jump_in && !irq_accept_in |=> pc_out == $past(pc_out) + 13'h1)
        else $error("pc did not step by one");
    // ====================
    // data side
    direct_addr_a: assert property (acc && reg_addr_in != `INDIRECT_OFS |=>
        data_addr_out == {$past(status_out[6:5]), $past(reg_addr_in)})
        else $error("direct address wrong");
    indirect_addr_a: assert property (acc && reg_addr_in == `INDIRECT_OFS |=>
        data_addr_out == {$past(status_out[6]), $past(indirect_pointer_reg_out)})
        else $error("indirect address wrong");
    status_mirror_a: assert property (data_rd_in && !data_wr_in && reg_addr_in == `STATUS_OFS |=>
        data_rd_out == $past(status_out) && region_out == 2'h3)
        else $error("status read wrong");
    gpr_region_a: assert property (acc && reg_addr_in >= `SPECIAL_LIMIT |=> region_out == 2'h1)
        else $error("ram offset not in ram region");
    // offsets from 05h up to the ram boundary are peripheral registers in every bank
    periph_select_a: assert property (acc && reg_addr_in >= 7'h05 && reg_addr_in < `SPECIAL_LIMIT |=>
        periph_sel_out)
        else $error("peripheral register not selected");
    ee_pointer_a: assert property (ee_ptr_wr_in |=>
        ee_addr_out == (LARGE_VARIANT ? $past(ee_ptr_in) : {1'b0, $past(ee_ptr_in[6:0])}))
        else $error("eeprom address wrong");
endmodule
bind memory_map_bank_decoder memory_map_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk (.*);
`default_nettype wire

/* File: tb/core_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model (
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic run_in,
    output logic      pc_advance_out
);
    // one fetch per cycle while running, nothing while held in reset
    always_ff @(posedge ref_clk_in) begin
        pc_advance_out <= run_in && !sys_rst_in;
    end
endmodule
`default_nettype wire

/* File: tb/memory_map_bank_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.svh"
module memory_map_bank_decoder_tb;
    logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, run = 1'b0, pc_advance_in, pc_jump_in = 1'b0;
    logic        irq_accept_in = 1'b0, rom_load_en_in = 1'b0, data_rd_in = 1'b0, data_wr_in = 1'b0;
    logic        ee_ptr_wr_in = 1'b0, periph_sel_out;
    logic [12:0] pc_target_in = '0, rom_load_addr_in = '0, pc_out;
    logic [13:0] rom_load_word_in = '0, fetch_word_out;
    logic [6:0]  reg_addr_in = '0;
    logic [7:0]  wr_data_in = '0, ee_ptr_in = '0, data_rd_out, status_out, indirect_pointer_reg_out, ee_addr_out;
    logic [7:0]  big_ee_addr;
    logic [13:0] big_fetch_word;
    logic [8:0]  data_addr_out;
    logic [1:0]  region_out;
    int          err_total = 0, n_tests = 0;
    memory_map_bank_decoder dut (.*);
    // large form on the same stimulus: wider program space and eeprom pointer
    memory_map_bank_decoder #(.LARGE_VARIANT(1'b1)) dut_big (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .pc_advance_in(pc_advance_in),
        .pc_jump_in(pc_jump_in), .pc_target_in(pc_target_in), .irq_accept_in(irq_accept_in),
        .rom_load_en_in(rom_load_en_in), .rom_load_addr_in(rom_load_addr_in), .rom_load_word_in(rom_load_word_in),
        .pc_out(), .fetch_word_out(big_fetch_word), .data_rd_in(data_rd_in), .data_wr_in(data_wr_in),
        .reg_addr_in(reg_addr_in), .wr_data_in(wr_data_in), .data_rd_out(), .data_addr_out(), .region_out(),
        .periph_sel_out(), .status_out(), .indirect_pointer_reg_out(), .ee_ptr_wr_in(ee_ptr_wr_in),
        .ee_ptr_in(ee_ptr_in), .ee_addr_out(big_ee_addr)
    );
    core_fetch_model core (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .run_in(run), .pc_advance_out(pc_advance_in));
    always #2.5 ref_clk_in = ~ref_clk_in;
    // ====================
    // shared tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task finish_test();
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task dop(input logic r, input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        data_rd_in <= r;
        data_wr_in <= w;
        reg_addr_in <= a;
        wr_data_in <= d;
        @(posedge ref_clk_in);
        data_rd_in <= 1'b0;
        data_wr_in <= 1'b0;
        #1;
    endtask
    // extra edge so the fetch of the new pc has landed
    task pop(input logic i, input logic j, input logic [12:0] t);
        @(posedge ref_clk_in);
        irq_accept_in <= i;
        pc_jump_in <= j;
        pc_target_in <= t;
        @(posedge ref_clk_in);
        irq_accept_in <= 1'b0;
        pc_jump_in <= 1'b0;
        @(posedge ref_clk_in);
        #1;
    endtask
    // ====================
    // scenarios
    task t_pc();
        chk(pc_out, 13'h0000);
        chk(status_out, `STATUS_RESET);
        pop(1'b1, 1'b0, 13'h0000);
        chk(pc_out, `IRQ_VECTOR);
        pop(1'b0, 1'b1, 13'h1FFE);
        run <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        run <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk(pc_out, 13'h0000);
    endtask
    task t_wrap();
        @(posedge ref_clk_in);
        rom_load_en_in <= 1'b1;
        rom_load_addr_in <= 13'h0820;
        rom_load_word_in <= 14'h1357;
        @(posedge ref_clk_in);
        rom_load_addr_in <= 13'h0420;
        rom_load_word_in <= 14'h2A5C;
        @(posedge ref_clk_in);
        rom_load_en_in <= 1'b0;
        // small part folds both loads onto one word, large part keeps them apart
        for (int k = 0; k < 8; k++) begin
            pop(1'b0, 1'b1, {k[2:0], 10'h020});
            chk(fetch_word_out, 14'h2A5C);
            chk(big_fetch_word, k[0] ? 14'h2A5C : 14'h1357);
        end
    endtask
    task t_bank();
        for (int b = 0; b < 4; b++) begin
            dop(1'b0, 1'b1, `STATUS_OFS, {1'b0, b[1:0], 5'h18});
            chk(status_out, {1'b0, b[1:0], 5'h18});
            dop(1'b1, 1'b0, `STATUS_OFS, 8'h00);
            chk(data_rd_out, {1'b0, b[1:0], 5'h18});
            chk(data_addr_out, {b[1:0], 7'h03});
            chk(periph_sel_out, 1'b0);
            dop(1'b1, 1'b0, 7'h7F, 8'h00);
            chk(data_addr_out, {b[1:0], 7'h7F});
            chk(region_out, 2'h1);
            dop(1'b1, 1'b0, 7'h10, 8'h00);
            chk(region_out, 2'h0);
            chk(periph_sel_out, 1'b1);
        end
    endtask
    task t_indirect();
        dop(1'b0, 1'b1, `STATUS_OFS, 8'h18);
        dop(1'b0, 1'b1, 7'h25, 8'h3C);
        dop(1'b0, 1'b1, `POINTER_OFS, 8'h25);
        chk(indirect_pointer_reg_out, 8'h25);
        // fetch keeps stepping while the data read runs in the same cycles
        run <= 1'b1;
        dop(1'b1, 1'b0, `INDIRECT_OFS, 8'h00);
        run <= 1'b0;
        chk(data_rd_out, 8'h3C);
        chk(data_addr_out, 9'h025);
        chk(pc_out, 13'h1C21);
        chk(fetch_word_out, 14'h2A5C);
        @(posedge ref_clk_in);
        ee_ptr_wr_in <= 1'b1;
        ee_ptr_in <= 8'hFF;
        @(posedge ref_clk_in);
        ee_ptr_wr_in <= 1'b0;
        #1;
        chk(ee_addr_out, 8'h7F);
        chk(big_ee_addr, 8'hFF);
    endtask
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        #1;
        t_pc();
        t_wrap();
        t_bank();
        t_indirect();
        finish_test();
    end
endmodule
`default_nettype wire
